//--- include/cpusup_pkg.sv
/*
 * Shared constants and types of the processor supervisor: timing figures,
 * synchroniser bit positions and reset values, and the reset sequencer states.
 * Assumes a single 50 MHz reference clock; nothing else is needed.
 */
package cpusup_pkg;

	// Reference clock
	localparam int CPUSUP_CLK_HZ     = 50_000_000;  // Nominal clock rate
	localparam int CPUSUP_CLK_NS     = 20;          // Clock period in ns

	// Timed intervals, in their own units
	localparam int CPUSUP_STRETCH_MS = 200;         // Reset release stretch
	localparam int CPUSUP_WDOG_MS    = 1560;        // Watchdog timeout
	localparam int CPUSUP_MS_PER_S   = 1000;        // Milliseconds per second

	// Width of the shared timer counters; holds the watchdog count
	localparam int CPUSUP_CNT_W      = 27;

	// Bit positions of the synchronised input bundle
	localparam int CPUSUP_SYNC_W     = 6;
	localparam int SI_SUPPLY         = 0;           // Supply below reset_trip_level
	localparam int SI_SENSE          = 1;           // Sense input below reference
	localparam int SI_MR             = 2;           // manual_reset_n
	localparam int SI_KICK           = 3;           // watchdog_kick_in
	localparam int SI_PF             = 4;           // powerfail_sense_in below reference
	localparam int SI_LL             = 5;           // Supply below low-line level

	// Synchroniser reset value: supply and sense low, MR idle high, warnings low
	localparam logic [CPUSUP_SYNC_W-1:0] CPUSUP_SYNC_RST = 6'h37;

	// Reset sequencer states, one-hot
	typedef enum logic [2:0] {
		ST_HOLD    = 3'h1,  // Cause present, reset held
		ST_STRETCH = 3'h2,  // Cause gone, release timer running
		ST_RUN     = 3'h4   // Reset released
	} cpusup_state_t;

endpackage : cpusup_pkg

//--- include/cpusup_sync_if.sv
/*
 * Bundle between the supervisor top and its input synchroniser: raw
 * asynchronous levels in, clock-aligned levels out.
 * Assumes both ends run on the same reference clock.
 */
`timescale 1ns/10ps
interface cpusup_sync_if #(
	parameter int W = 6
);
	logic [W-1:0] raw;   // Levels as they arrive at the pins
	logic [W-1:0] sync;  // Levels after two register stages

	// Synchroniser end
	modport stage (input raw, output sync);
	// Consuming end
	modport user (output raw, input sync);
endinterface : cpusup_sync_if

//--- core/cpusup_sync.sv
/*
 * Two-stage synchroniser for every comparator and manual reset level.
 * Assumes levels may change at any time relative to ref_clk; clk_en freezes
 * both stages.
 */
`timescale 1ns/10ps
module cpusup_sync #(
	parameter int                  W       = 6,
	parameter logic [W-1:0]        RST_VAL = '0
) (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic reset,
	input  wire logic clk_en,
	// Level bundle
	cpusup_sync_if.stage bus
);
	logic [W-1:0] meta;  // First stage, read only by the second

	////////////////////////////////////////////////////////////////////////////////
	// One chain per bit; reset constants hold supply, sense and warnings low, manual reset idle
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			// Two flops in series per level
			always_ff @(posedge ref_clk or posedge reset) begin
				if (reset) begin
					meta[i]     <= RST_VAL[i];
					bus.sync[i] <= RST_VAL[i];
				end else if (clk_en) begin
					meta[i]     <= bus.raw[i];
					bus.sync[i] <= meta[i];
				end
			end
		end
	endgenerate

endmodule : cpusup_sync

//--- core/cpusup_top.sv
/*
 * Processor supervisor: reset sequencer with release stretch, manual reset,
 * watchdog, power-fail warning and low-line warning.
 * Assumes analog comparators outside deliver digital levels, a free-running
 * ref_clk, and a processor that toggles the watchdog input regularly.
 */
`timescale 1ns/10ps
module cpusup_top
	import cpusup_pkg::*;
#(
	parameter int CLK_HZ         = cpusup_pkg::CPUSUP_CLK_HZ,
	parameter int STRETCH_CYCLES = CLK_HZ / cpusup_pkg::CPUSUP_MS_PER_S * cpusup_pkg::CPUSUP_STRETCH_MS,
	parameter int WDOG_CYCLES    = CLK_HZ / cpusup_pkg::CPUSUP_MS_PER_S * cpusup_pkg::CPUSUP_WDOG_MS
) (
	// Clock, reset and enable
	input  wire logic ref_clk,
	input  wire logic reset,
	input  wire logic clk_en,
	// Comparator results, high while the monitored level is below its trip
	input  wire logic supply_low,
	input  wire logic sense_low,
	input  wire logic powerfail_sense_low,
	input  wire logic lowline_low,
	// Variant select: high trips reset on the sense input instead of supply
	input  wire logic adj_mode,
	// Processor side inputs
	input  wire logic manual_reset_n,
	input  wire logic watchdog_kick_in,
	// Supervisor outputs
	output wire logic reset_out_n,
	output wire logic reset_out,
	output wire logic watchdog_expired_n,
	output wire logic powerfail_warn_n,
	output wire logic low_line_n
);
	import cpusup_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Derived counts

	// Last stretch count and timeout count, sized to the counters
	localparam logic [CPUSUP_CNT_W-1:0] STRETCH_LAST = CPUSUP_CNT_W'(STRETCH_CYCLES - 1);
	localparam logic [CPUSUP_CNT_W-1:0] WDOG_LIMIT   = CPUSUP_CNT_W'(WDOG_CYCLES);
	localparam logic [CPUSUP_CNT_W-1:0] CNT_ONE      = 27'h0000001;
	localparam logic [CPUSUP_CNT_W-1:0] CNT_ZERO     = 27'h0000000;

	////////////////////////////////////////////////////////////////////////////////
	// Declarations

	cpusup_sync_if #(.W(CPUSUP_SYNC_W)) sync_bus ();  // Synchroniser bundle

	cpusup_state_t               state;             // Reset sequencer state
	cpusup_state_t               next_state;        // Its next value
	logic [CPUSUP_CNT_W-1:0]     stretch_cnt;       // Cycles since cause left
	logic [CPUSUP_CNT_W-1:0]     next_stretch_cnt;
	logic [CPUSUP_CNT_W-1:0]     wd_cnt;            // Cycles since last kick
	logic [CPUSUP_CNT_W-1:0]     next_wd_cnt;
	logic                        kick_prev;         // Kick level one cycle back
	logic                        reset_n_q;         // Registered reset output
	logic                        wdo_n_q;           // Registered watchdog output
	logic                        pfo_n_q;           // Registered power-fail warning
	logic                        ll_n_q;            // Registered low-line warning

	wire logic                   supply_s;          // Synchronised supply low
	wire logic                   sense_s;           // Synchronised sense low
	wire logic                   mr_n_s;            // Synchronised manual reset
	wire logic                   kick_s;            // Synchronised kick level
	wire logic                   pf_s;              // Synchronised power-fail low
	wire logic                   ll_s;              // Synchronised low-line low
	wire logic                   trip_low;          // Selected trip comparator
	wire logic                   cause;             // Any reason to hold reset
	wire logic                   stretch_done;      // Stretch timer at its end
	wire logic                   kick_edge;         // Kick changed level
	wire logic                   wd_expired;        // Watchdog timed out
	wire logic                   released;          // Sequencer in run state

	// Run-state decode, shared by output logic and checks
	function automatic logic cpusup_is_run(input cpusup_state_t s);
		return s == ST_RUN;
	endfunction : cpusup_is_run

	////////////////////////////////////////////////////////////////////////////////
	// Input synchronisation

	// Pack raw levels in bundle order
	assign sync_bus.raw[SI_SUPPLY] = supply_low;
	assign sync_bus.raw[SI_SENSE]  = sense_low;
	assign sync_bus.raw[SI_MR]     = manual_reset_n;
	assign sync_bus.raw[SI_KICK]   = watchdog_kick_in;
	assign sync_bus.raw[SI_PF]     = powerfail_sense_low;
	assign sync_bus.raw[SI_LL]     = lowline_low;

	// All levels pass two flops before any logic sees them
	cpusup_sync #(
		.W       (CPUSUP_SYNC_W),
		.RST_VAL (CPUSUP_SYNC_RST)
	) u_sync (
		.ref_clk (ref_clk),
		.reset   (reset),
		.clk_en  (clk_en),
		.bus     (sync_bus.stage)
	);

	// Unpack clean levels
	assign supply_s = sync_bus.sync[SI_SUPPLY];
	assign sense_s  = sync_bus.sync[SI_SENSE];
	assign mr_n_s   = sync_bus.sync[SI_MR];
	assign kick_s   = sync_bus.sync[SI_KICK];
	assign pf_s     = sync_bus.sync[SI_PF];
	assign ll_s     = sync_bus.sync[SI_LL];

	////////////////////////////////////////////////////////////////////////////////
	// Reset sequencer

	// Trip source follows the variant strap
	assign trip_low = adj_mode ? sense_s : supply_s;

	// A low manual reset is a cause just like low supply; every bounce low
	// simply restarts the hold, so one clean stretched reset results
	assign cause        = trip_low | ~mr_n_s;
	assign stretch_done = (stretch_cnt == STRETCH_LAST);
	assign released     = cpusup_is_run(state);

	// Next state
	always_comb begin
		next_state = ST_HOLD;
		case (state)
			ST_HOLD: begin
				// Stay while rising or falling below trip
				next_state = cause ? ST_HOLD : ST_STRETCH;
			end
			ST_STRETCH: begin
				if (cause) begin
					next_state = ST_HOLD;
				end else if (stretch_done) begin
					next_state = ST_RUN;
				end else begin
					next_state = ST_STRETCH;
				end
			end
			ST_RUN: begin
				// Any dip pulses reset again
				next_state = cause ? ST_HOLD : ST_RUN;
			end
			default: begin
				next_state = ST_HOLD;
			end
		endcase
	end

	// Stretch timer counts only while stretching with no cause; a fresh
	// brownout zeroes it, so the full stretch follows its end
	assign next_stretch_cnt = (state == ST_STRETCH && !cause) ? stretch_cnt + CNT_ONE : CNT_ZERO;

	// State and stretch registers
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state       <= ST_HOLD;
			stretch_cnt <= CNT_ZERO;
		end else if (clk_en) begin
			state       <= next_state;
			stretch_cnt <= next_stretch_cnt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Watchdog

	// Either edge of the kick counts; the bench relies on regular kicks
	assign kick_edge  = kick_s ^ kick_prev;
	assign wd_expired = (wd_cnt == WDOG_LIMIT);

	// Timer cleared while reset is held, so feeding the output back to the
	// manual reset gives one reset and the output rises again
	assign next_wd_cnt = (!released || kick_edge) ? CNT_ZERO :
		(wd_expired ? wd_cnt : wd_cnt + CNT_ONE);

	// Timer registers
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			wd_cnt    <= CNT_ZERO;
			kick_prev <= 1'h0;
		end else if (clk_en) begin
			wd_cnt    <= next_wd_cnt;
			kick_prev <= kick_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Output registers

	// Reset and watchdog outputs load on the same edge, so a supply dip pulls
	// both low together and reset overrides the interrupt
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			reset_n_q <= 1'h0;
			wdo_n_q   <= 1'h0;
		end else if (clk_en) begin
			reset_n_q <= cpusup_is_run(next_state);
			wdo_n_q   <= ~(trip_low | wd_expired);
		end
	end

	// Warning comparators, no link to the reset or watchdog path
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			pfo_n_q <= 1'h0;
			ll_n_q  <= 1'h0;
		end else if (clk_en) begin
			pfo_n_q <= ~pf_s;
			ll_n_q  <= ~ll_s;
		end
	end

	// Drive pins; active-high reset is a pure inverter of the low one
	assign reset_out_n        = reset_n_q;
	assign reset_out          = ~reset_n_q;
	assign watchdog_expired_n = wdo_n_q;
	assign powerfail_warn_n   = pfo_n_q;
	assign low_line_n         = ll_n_q;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	// Trip holds reset low from the next edge
	a_trip_holds_reset: assert property (
		@(posedge ref_clk) disable iff (reset)
		clk_en && trip_low |=> !reset_out_n
	) else $error("reset released while trip level low");

	// Release only after a full stretch
	a_release_after_stretch: assert property (
		@(posedge ref_clk) disable iff (reset)
		$rose(reset_out_n) |-> $past(state) == ST_STRETCH && $past(stretch_cnt) == STRETCH_LAST
	) else $error("reset released before stretch end");

	// Dip while running pulses reset
	a_brownout_pulse: assert property (
		@(posedge ref_clk) disable iff (reset)
		clk_en && released && trip_low |=> state == ST_HOLD ##0 !reset_out_n
	) else $error("brownout did not assert reset");

	// Cause during stretch restarts the timer
	a_stretch_restart: assert property (
		@(posedge ref_clk) disable iff (reset)
		clk_en && state == ST_STRETCH && cause |=> state == ST_HOLD && stretch_cnt == CNT_ZERO
	) else $error("brownout did not restart stretch");

	// Power-down keeps reset low
	a_powerdown_low: assert property (
		@(posedge ref_clk) disable iff (reset)
		clk_en && !reset_out_n && cause |=> !reset_out_n
	) else $error("reset rose during power-down");

	// Both polarities always opposite
	a_reset_inverse: assert property (
		@(posedge ref_clk) disable iff (reset)
		reset_out == !reset_out_n
	) else $error("reset outputs not inverse");

	// Sense input trips in adjustable mode
	a_adj_sense_trip: assert property (
		@(posedge ref_clk) disable iff (reset)
		clk_en && adj_mode && sense_s |=> !reset_out_n && !watchdog_expired_n
	) else $error("sense input did not trip reset");

	// Timeout drives watchdog output low
	a_wdog_timeout: assert property (
		@(posedge ref_clk) disable iff (reset)
		clk_en && wd_expired |=> !watchdog_expired_n
	) else $error("watchdog timeout not signalled");

	// Good trip level and a timer short of its limit keep the output high
	a_wdog_no_early: assert property (
		@(posedge ref_clk) disable iff (reset)
		clk_en && !trip_low && !wd_expired |=> watchdog_expired_n
	) else $error("watchdog output fell before timeout");

	// Supply low: both outputs low on the same edge, and watchdog output
	// rises the edge after supply returns with the timer clear
	a_wdog_with_reset: assert property (
		@(posedge ref_clk) disable iff (reset)
		clk_en && trip_low |=> !watchdog_expired_n && !reset_out_n
	) else $error("watchdog and reset not low together");

	a_wdog_quick_release: assert property (
		@(posedge ref_clk) disable iff (reset)
		clk_en && !trip_low && $past(trip_low) && !wd_expired |=> watchdog_expired_n
	) else $error("watchdog output stretched after supply return");

	// Power-fail warning tracks its comparator
	a_pfo_follows: assert property (
		@(posedge ref_clk) disable iff (reset)
		clk_en |=> powerfail_warn_n == !$past(pf_s)
	) else $error("power-fail warning wrong");

	// Low-line warning tracks its comparator
	a_lowline_follows: assert property (
		@(posedge ref_clk) disable iff (reset)
		clk_en |=> low_line_n == !$past(ll_s)
	) else $error("low-line warning wrong");

	// Manual reset low holds reset
	a_manual_holds: assert property (
		@(posedge ref_clk) disable iff (reset)
		clk_en && !mr_n_s |=> !reset_out_n
	) else $error("manual reset ignored");

	// Kick edge clears the timer while running
	a_kick_clears: assert property (
		@(posedge ref_clk) disable iff (reset)
		clk_en && kick_edge |=> wd_cnt == CNT_ZERO
	) else $error("kick did not clear watchdog");

	// Scenarios worth seeing
	c_release: cover property (@(posedge ref_clk) disable iff (reset) $rose(reset_out_n));
	c_brownout: cover property (@(posedge ref_clk) disable iff (reset) released && trip_low);
	c_restart: cover property (@(posedge ref_clk) disable iff (reset) state == ST_STRETCH && cause);
	c_timeout: cover property (@(posedge ref_clk) disable iff (reset) $fell(watchdog_expired_n) && released);
	c_manual: cover property (@(posedge ref_clk) disable iff (reset) released && !mr_n_s);

endmodule : cpusup_top

//--- sim/cpusup_cpu_model.sv
/*
 * Processor stand-in for the supervisor: toggles the watchdog kick line at a
 * fixed spacing while it is out of reset and allowed to run.
 * Assumes ref_clk is shared with the supervisor; changes land on rising edges
 * by non-blocking assignment.
 */
`timescale 1ns/10ps
module cpusup_cpu_model #(
	parameter int KICK_GAP = 30  // Cycles between kick edges
) (
	// Clock
	input  wire logic ref_clk,
	// Supervisor side
	input  wire logic reset_out_n,
	input  wire logic kick_en,
	output var  logic watchdog_kick_in
);
	int gap_cnt = 0;  // Cycles since the last kick edge

	initial watchdog_kick_in = 1'h0;

	////////////////////////////////////////////////////////////////////////////
	// Kick generator; a held processor runs no code, so the count restarts
	// Rising edge, so the bench's falling-edge enable never races the count
	always @(posedge ref_clk) begin
		if (!reset_out_n || !kick_en) begin
			gap_cnt <= 0;
		end else if (gap_cnt == KICK_GAP - 1) begin
			gap_cnt          <= 0;
			watchdog_kick_in <= ~watchdog_kick_in;
		end else begin
			gap_cnt <= gap_cnt + 1;
		end
	end
endmodule : cpusup_cpu_model

//--- sim/cpusup_top_bench.sv
/*
 * Self-checking bench for the supervisor with shortened stretch and watchdog.
 * Assumes a three-edge input latency and a stretch counted in enabled edges.
 */
`timescale 1ns/10ps
module cpusup_top_bench;
	import cpusup_pkg::*;

	localparam int S = 20;  // Short release stretch
	localparam int W = 50;  // Short watchdog timeout
	localparam int K = 30;  // Processor kick spacing

	// Stimulus, all set at time zero
	logic ref_clk = 1'h0, reset = 1'h1;
	logic supply_low = 1'h1, sense_low = 1'h0, adj_mode = 1'h0;
	logic powerfail_sense_low = 1'h0, lowline_low = 1'h0;
	logic manual_reset_n = 1'h1, kick_en = 1'h1, clk_en = 1'h1;
	// Observed outputs
	wire logic reset_out_n, reset_out, watchdog_expired_n, powerfail_warn_n, low_line_n, watchdog_kick_in;
	int n_fail = 0;     // Mismatches
	int tests_run = 0;  // Comparisons

	always #10 ref_clk = ~ref_clk;

	cpusup_top #(.STRETCH_CYCLES(S), .WDOG_CYCLES(W)) uut (
		.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
		.supply_low(supply_low), .sense_low(sense_low),
		.powerfail_sense_low(powerfail_sense_low), .lowline_low(lowline_low),
		.adj_mode(adj_mode), .manual_reset_n(manual_reset_n),
		.watchdog_kick_in(watchdog_kick_in), .reset_out_n(reset_out_n),
		.reset_out(reset_out), .watchdog_expired_n(watchdog_expired_n),
		.powerfail_warn_n(powerfail_warn_n), .low_line_n(low_line_n)
	);

	cpusup_cpu_model #(.KICK_GAP(K)) cpu (
		.ref_clk(ref_clk), .reset_out_n(reset_out_n),
		.kick_en(kick_en), .watchdog_kick_in(watchdog_kick_in)
	);

	////////////////////////////////////////////////////////////////////////////
	// Helpers
	task check(input logic [31:0] seen, input logic [31:0] expd);
		tests_run++;
		if (seen !== expd) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, expd);
		end
	endtask : check

	// Let edges pass, then look once updates have landed
	task step(input int n);
		repeat (n) begin
			@(posedge ref_clk);
			#1;
		end
	endtask : step

	// Edges until an output (0 reset, 1 watchdog) shows a level; bounded
	task wait_for(input int sel, input logic val, output int n);
		n = 0;
		do begin
			step(1);
			n++;
		end while (((sel == 0) ? reset_out_n : watchdog_expired_n) !== val && n < 1000);
	endtask : wait_for

	task final_report;
		if (n_fail == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : final_report

	// Inverted output watched throughout
	always @(negedge ref_clk) begin
		check(32'(reset_out), 32'(!reset_out_n));
	end

	////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task t_power_up;
		int n;
		step(30);
		check(32'(reset_out_n), 32'h0);
		check(32'(watchdog_expired_n), 32'h0);
		@(negedge ref_clk) supply_low = 1'h0;
		step(2);
		check(32'(watchdog_expired_n), 32'h0);
		step(1);
		check(32'(watchdog_expired_n), 32'h1);
		wait_for(0, 1'h1, n);
		check(32'(n), 32'(S));
	endtask : t_power_up

	// Warnings move alone; reset must not care
	task t_warnings;
		@(negedge ref_clk) powerfail_sense_low = 1'h1;
		step(2);
		check(32'(powerfail_warn_n), 32'h1);
		step(1);
		check(32'(powerfail_warn_n), 32'h0);
		check(32'(reset_out_n), 32'h1);
		@(negedge ref_clk) lowline_low = 1'h1;
		step(3);
		check(32'(low_line_n), 32'h0);
		check(32'(reset_out_n), 32'h1);
		@(negedge ref_clk) {powerfail_sense_low, lowline_low} = 2'h0;
		step(3);
		check(32'(powerfail_warn_n), 32'h1);
		check(32'(low_line_n), 32'h1);
	endtask : t_warnings

	// Dip, then a long power-down hold, then recovery
	task t_brownout;
		int n;
		@(negedge ref_clk) supply_low = 1'h1;
		step(2);
		check(32'(reset_out_n), 32'h1);
		step(1);
		check(32'(reset_out_n), 32'h0);
		check(32'(watchdog_expired_n), 32'h0);
		step(3 * S);
		check(32'(reset_out_n), 32'h0);
		@(negedge ref_clk) supply_low = 1'h0;
		wait_for(0, 1'h1, n);
		check(32'(n), 32'(3 + S));
	endtask : t_brownout

	// Second dip half way through the stretch restarts it
	task t_mid_reset;
		int n;
		@(negedge ref_clk) supply_low = 1'h1;
		step(5);
		@(negedge ref_clk) supply_low = 1'h0;
		step(3 + S / 2);
		@(negedge ref_clk) supply_low = 1'h1;
		step(2);
		@(negedge ref_clk) supply_low = 1'h0;
		wait_for(0, 1'h1, n);
		check(32'(n), 32'(3 + S));
	endtask : t_mid_reset

	// Bouncing switch: one stretched release counted from the last bounce
	task t_manual;
		int n;
		@(negedge ref_clk) manual_reset_n = 1'h0;
		step(6);
		check(32'(reset_out_n), 32'h0);
		for (int i = 0; i < 3; i++) begin
			@(negedge ref_clk) manual_reset_n = 1'h1;
			step(3);
			@(negedge ref_clk) manual_reset_n = 1'h0;
			step(2);
			check(32'(reset_out_n), 32'h0);
		end
		@(negedge ref_clk) manual_reset_n = 1'h1;
		wait_for(0, 1'h1, n);
		check(32'(n), 32'(3 + S));
	endtask : t_manual

	// Adjustable variant ignores the supply and trips on the sense level
	task t_adjust;
		int n;
		@(negedge ref_clk) {adj_mode, supply_low} = 2'h3;
		step(5);
		check(32'(reset_out_n), 32'h1);
		check(32'(watchdog_expired_n), 32'h1);
		@(negedge ref_clk) {supply_low, sense_low} = 2'h1;
		step(3);
		check(32'(reset_out_n), 32'h0);
		check(32'(watchdog_expired_n), 32'h0);
		@(negedge ref_clk) sense_low = 1'h0;
		wait_for(0, 1'h1, n);
		check(32'(n), 32'(3 + S));
		@(negedge ref_clk) adj_mode = 1'h0;
	endtask : t_adjust

	// Silent processor times out; kicks on both edges keep it quiet
	task t_watchdog;
		int n;
		@(negedge ref_clk) {kick_en, manual_reset_n} = 2'h0;
		step(4);
		@(negedge ref_clk) manual_reset_n = 1'h1;
		wait_for(0, 1'h1, n);
		wait_for(1, 1'h0, n);
		check(32'(n), 32'(W + 1));
		@(negedge ref_clk) kick_en = 1'h1;
		wait_for(1, 1'h1, n);
		// Model edge count, two sync stages, timer clear, then the output
		check(32'(n), 32'(K + 4));
		step(3 * W);
		check(32'(watchdog_expired_n), 32'h1);
		check(32'(reset_out_n), 32'h1);
	endtask : t_watchdog

	// Clock enable low freezes the stretch timer and the synchronisers
	task t_freeze;
		int n;
		@(negedge ref_clk) supply_low = 1'h1;
		step(5);
		@(negedge ref_clk) supply_low = 1'h0;
		step(5);
		@(negedge ref_clk) {clk_en, powerfail_sense_low} = 2'h1;
		step(10);
		check(32'(reset_out_n), 32'h0);
		check(32'(powerfail_warn_n), 32'h1);
		@(negedge ref_clk) {clk_en, powerfail_sense_low} = 2'h2;
		wait_for(0, 1'h1, n);
		// Five enabled edges passed before the freeze
		check(32'(n), 32'(3 + S - 5));
	endtask : t_freeze

	// Reset in mid-run: outputs low at once, then a full power-up stretch
	task t_reset_again;
		int n;
		@(negedge ref_clk) reset = 1'h1;
		step(2);
		check(32'(reset_out_n), 32'h0);
		check(32'(watchdog_expired_n), 32'h0);
		check(32'(powerfail_warn_n), 32'h0);
		check(32'(low_line_n), 32'h0);
		@(negedge ref_clk) reset = 1'h0;
		wait_for(0, 1'h1, n);
		check(32'(n), 32'(3 + S));
		check(32'(powerfail_warn_n), 32'h1);
		check(32'(low_line_n), 32'h1);
		check(32'(watchdog_expired_n), 32'h1);
	endtask : t_reset_again

	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (10) @(posedge ref_clk);
		@(negedge ref_clk) reset = 1'h0;
		t_power_up();
		t_warnings();
		t_brownout();
		t_mid_reset();
		t_manual();
		t_adjust();
		t_watchdog();
		t_freeze();
		t_reset_again();
		final_report();
	end

	// Hang guard, far above the few hundred cycles the scenarios need
	initial begin
		#1_000_000;
		n_fail++;
		final_report();
	end
endmodule : cpusup_top_bench
